// ### rtl/ihc_pkg.sv
// Constants shared by the interrupt hold-off controller
`default_nettype none
package ihc_pkg;
   // Register offsets, byte addresses
   localparam logic [11:0] IHC_OFS_IRQ_STATUS = 12'h00C8;
   localparam logic [11:0] IHC_OFS_IRQ_LINE_CONFIG = 12'h00CC;
   // Field positions of irq_line_config
   localparam int IHC_POS_MASTER = 19;
   localparam int IHC_POS_OUT_EN = 18;
   localparam int IHC_POS_RESTART = 9;
   localparam int IHC_POS_ACTIVE = 8;
   localparam int IHC_POS_INTERVAL_LSB = 0;
   localparam int IHC_INTERVAL_W = 8;
   // Field positions of the status register
   localparam int IHC_POS_WAKE = 1;
   localparam int IHC_POS_DMA = 0;
   // Values after reset
   localparam logic [7:0] IHC_RST_INTERVAL = 8'h00;
   localparam logic IHC_RST_OUT_EN = 1'b0;
   // Timing: hold-off unit and clock period, both in ns
   localparam int IHC_UNIT_NS = 10000;
   localparam int IHC_CLK_NS = 100;
   localparam int IHC_TICK_CYCLES = (IHC_UNIT_NS + IHC_CLK_NS - 1) / IHC_CLK_NS;
   localparam int IHC_PRE_W = 7;
   localparam logic [IHC_PRE_W-1:0] IHC_PRE_LAST = IHC_PRE_W'(IHC_TICK_CYCLES - 1);
endpackage : ihc_pkg
`default_nettype wire

// ### rtl/ihc_irq_holdoff_ctrl.sv
// Interrupt combiner with programmable hold-off on the request line
//
// Functional notes
// - Wake flag sets on MAC wake or energy-detect
// - Wake flag read-only; clears when wake sources clear
// - Status bit 0 mirrors DMA interrupt, read-only
// - Master bit high when any enabled interrupt active
// - Output enable clear keeps request line low
// - Eight-bit interval in 10 us units, reset zero
// - Line stays low for interval after clear
// - Interval starts when asserted sources clear
// - Restart bit reloads counter, starts fresh interval
// - Active bit high during interval; line blocked
// - Writing zero interval stops hold-off immediately
// - New non-zero interval applies to later interrupts
// - Wake interrupt bypasses the hold-off interval
// - Other sources count only when enabled
// - DMA source gated by its own enable
`default_nettype none
module ihc_irq_holdoff_ctrl
   import ihc_pkg::*;
#(
   parameter int NUM_SRC = 8 // Count of other maskable sources
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [11:0] reg_addr, // Byte address of register access
   input wire logic reg_wr, // Write strobe, one cycle
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata, // Read data, registered
   input wire logic wake_event, // Pulse: wake frame or energy detect
   input wire logic [1:0] wakeup_source_bits, // From power_mgmt_control
   input wire logic wake_int_en,
   input wire logic dma_interrupt_flag, // Level from dma_control_status_reg
   input wire logic dma_int_en, // Enable held in dma_control_status_reg
   input wire logic [NUM_SRC-1:0] src_flags, // Other interrupt status bits
   input wire logic [NUM_SRC-1:0] src_enables, // Matching enable bits
   output logic irq_req // Request line towards host_bus_bridge
);

   initial begin
      if (NUM_SRC < 1 || NUM_SRC > 30) begin
         $error("NUM_SRC out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State
   logic wake_ff; // Wake event status flag
   logic out_en_ff; // Request line output enable
   logic [IHC_INTERVAL_W-1:0] interval_ff; // Programmed hold-off length
   logic [IHC_INTERVAL_W-1:0] cnt_ff; // Remaining hold-off ticks
   logic [IHC_PRE_W-1:0] pre_ff; // 10 us prescaler
   logic irq_ff; // Request line register
   logic [31:0] rdata_ff; // Read data register

   ////////////////////////////////////////////////////////////////////////////
   // Decode and combine
   wire cfg_wr = reg_wr && (reg_addr == IHC_OFS_IRQ_LINE_CONFIG);
   wire [IHC_INTERVAL_W-1:0] wr_interval =
      reg_wdata[IHC_POS_INTERVAL_LSB +: IHC_INTERVAL_W];
   wire wr_restart = cfg_wr && reg_wdata[IHC_POS_RESTART];
   wire dma_active = dma_interrupt_flag && dma_int_en;
   wire src_active = |(src_flags & src_enables);
   wire wake_active = wake_ff && wake_int_en;
   wire slow_active = dma_active || src_active;
   wire master = slow_active || wake_active;
   wire holdoff_active = (cnt_ff != '0);
   wire tick = (pre_ff == IHC_PRE_LAST);
   // Hold-off begins when the line was up and every enabled source has gone away
   wire clear_seen = irq_ff && !master;
   wire load_cnt = wr_restart || clear_seen;
   // Length to load; a same-cycle interval write takes effect at once
   wire [IHC_INTERVAL_W-1:0] load_len = cfg_wr ? wr_interval : interval_ff;

   logic [IHC_INTERVAL_W-1:0] nxt_cnt;
   always_comb begin
      if (cfg_wr && wr_interval == '0) begin
         nxt_cnt = '0;
      end else if (load_cnt) begin
         nxt_cnt = load_len;
      end else if (holdoff_active && tick) begin
         nxt_cnt = cnt_ff - 1'b1;
      end else begin
         nxt_cnt = cnt_ff;
      end
   end

   // Wake bypasses hold-off; slower sources wait for it to end
   wire nxt_irq = out_en_ff &&
      (wake_active || (slow_active && !(nxt_cnt != '0)));
   // Set wins over clear so an event in the clearing cycle is kept
   wire nxt_wake = wake_event || (wake_ff && (wakeup_source_bits != 2'b00));
   // Prescaler restarts on every load so each interval is whole units
   wire [IHC_PRE_W-1:0] nxt_pre = (load_cnt || tick || !holdoff_active) ?
      '0 : pre_ff + 1'b1;

   logic [31:0] nxt_rdata;
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (reg_addr == IHC_OFS_IRQ_LINE_CONFIG) begin
         nxt_rdata[IHC_POS_MASTER] = master;
         nxt_rdata[IHC_POS_OUT_EN] = out_en_ff;
         nxt_rdata[IHC_POS_ACTIVE] = holdoff_active;
         nxt_rdata[IHC_POS_INTERVAL_LSB +: IHC_INTERVAL_W] = interval_ff;
      end else if (reg_addr == IHC_OFS_IRQ_STATUS) begin
         nxt_rdata[IHC_POS_WAKE] = wake_ff;
         nxt_rdata[IHC_POS_DMA] = dma_interrupt_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   // Configuration fields written by software
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         out_en_ff <= IHC_RST_OUT_EN;
         interval_ff <= IHC_RST_INTERVAL;
      end else if (cfg_wr) begin
         out_en_ff <= reg_wdata[IHC_POS_OUT_EN];
         interval_ff <= wr_interval;
      end
   end

   // Counter, prescaler, flags and outputs
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cnt_ff <= '0;
         pre_ff <= '0;
         wake_ff <= 1'b0;
         irq_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         cnt_ff <= nxt_cnt;
         pre_ff <= nxt_pre;
         wake_ff <= nxt_wake;
         irq_ff <= nxt_irq;
         rdata_ff <= nxt_rdata;
      end
   end

   assign irq_req = irq_ff;
   assign reg_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_line_drop;
      irq_ff ##1 (!irq_ff && !master);
   endsequence

   AST_WAKE_SET: assert property (@(posedge ref_clk) disable iff (srst)
      wake_event |=> wake_ff)
      else $error("wake flag not set");
   AST_WAKE_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
      (wake_ff && wakeup_source_bits != 2'b00) |=> wake_ff)
      else $error("wake flag cleared early");
   AST_DMA_MIRROR: assert property (@(posedge ref_clk) disable iff (srst)
      reg_addr == IHC_OFS_IRQ_STATUS |=> reg_rdata[IHC_POS_DMA] == $past(dma_interrupt_flag))
      else $error("dma bit not mirrored");
   AST_MASTER: assert property (@(posedge ref_clk) disable iff (srst)
      reg_addr == IHC_OFS_IRQ_LINE_CONFIG |=>
      reg_rdata[IHC_POS_MASTER] == $past(slow_active || wake_active))
      else $error("master bit wrong");
   AST_OUT_EN: assert property (@(posedge ref_clk) disable iff (srst)
      !out_en_ff |=> !irq_req)
      else $error("line up while disabled");
   AST_HOLD_BLOCK: assert property (@(posedge ref_clk) disable iff (srst)
      (nxt_cnt != '0 && !wake_active) |=> !irq_req)
      else $error("line up during hold-off");
   AST_HOLD_START: assert property (@(posedge ref_clk) disable iff (srst)
      (clear_seen && !cfg_wr && interval_ff != '0) |=> cnt_ff == $past(interval_ff))
      else $error("hold-off not started");
   AST_ZERO_STOP: assert property (@(posedge ref_clk) disable iff (srst)
      (cfg_wr && wr_interval == '0 && reg_wdata[IHC_POS_OUT_EN] && slow_active)
      ##1 slow_active |=> irq_req)
      else $error("pending not issued");
   AST_RESTART: assert property (@(posedge ref_clk) disable iff (srst)
      (wr_restart && load_len != '0) |=> holdoff_active)
      else $error("restart ignored");
   AST_WAKE_BYPASS: assert property (@(posedge ref_clk) disable iff (srst)
      (out_en_ff && wake_active && !cfg_wr) |=> irq_req)
      else $error("wake delayed");
   // One cycle into an interval begun by the line dropping, the line must still be low, wake aside
   AST_MIN_GAP: assert property (@(posedge ref_clk) disable iff (srst)
      (s_line_drop ##0 (cnt_ff != '0 && !wake_active && !cfg_wr))
      |=> !irq_req)
      else $error("line returned too soon");
   AST_TICK: assert property (@(posedge ref_clk) disable iff (srst)
      (holdoff_active && tick && !load_cnt && !cfg_wr) |=> cnt_ff == $past(cnt_ff) - 1'b1)
      else $error("counter not decremented");

endmodule : ihc_irq_holdoff_ctrl
`default_nettype wire

// ### verif/ihc_bridge_model.sv
// Host bus bridge model: counts request assertions
`default_nettype none
module ihc_bridge_model (
   input wire logic ref_clk,
   input wire logic irq_req,
   output logic [7:0] irq_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_ff = 1'b0; // Line level one edge ago
   initial irq_seen = 8'h00;
   // One rising edge is one request taken by the bridge
   always @(posedge ref_clk) begin
      if (irq_req === 1'b1 && last_ff !== 1'b1) irq_seen <= irq_seen + 8'h01;
      last_ff <= irq_req;
   end
endmodule : ihc_bridge_model
`default_nettype wire

// ### verif/ihc_irq_holdoff_ctrl_tb.sv
// Self-checking bench for the interrupt hold-off controller
`default_nettype none
module ihc_irq_holdoff_ctrl_tb import ihc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
`define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
   logic ref_clk = 0, srst = 1, reg_wr = 0, wake_event = 0, wake_int_en = 0;
   logic dma_interrupt_flag = 0, dma_int_en = 0, irq_req, look = 0, look_irq = 0;
   logic [11:0] reg_addr = 12'h0000;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
   logic [1:0] wakeup_source_bits = 2'h0;
   logic [7:0] src_flags = 8'h00, src_enables = 8'h00, irq_seen;
   logic [31:0] exp_q[$]; // Expected results, oldest first
   int bad_count = 0, samples_checked = 0, n;
   localparam logic [11:0] CFG = IHC_OFS_IRQ_LINE_CONFIG;
   initial forever #50 ref_clk = ~ref_clk;
   ihc_irq_holdoff_ctrl uut (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .wake_event(wake_event), .wakeup_source_bits(wakeup_source_bits),
      .wake_int_en(wake_int_en), .dma_interrupt_flag(dma_interrupt_flag),
      .dma_int_en(dma_int_en), .src_flags(src_flags), .src_enables(src_enables),
      .irq_req(irq_req));
   ihc_bridge_model bridge (.ref_clk(ref_clk), .irq_req(irq_req), .irq_seen(irq_seen));
   // Watcher: outputs are settled at the falling edge
   always @(negedge ref_clk) begin
      if (look) `CMP(look_irq ? {31'h0, irq_req} : reg_rdata, exp_q.pop_front())
      look <= 1'b0;
   end
   task automatic end_sim();
      $display("checks %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim
   task automatic clk(input int k);
      repeat (k) @(posedge ref_clk);
   endtask : clk
   // Note an expectation and let the watcher judge it
   task automatic see(input logic is_irq, input logic [31:0] e);
      look_irq = is_irq;
      exp_q.push_back(e);
      look = 1'b1;
      @(negedge ref_clk);
      @(posedge ref_clk);
   endtask : see
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data shows one cycle after the address edge
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      @(posedge ref_clk);
      see(1'b0, e);
   endtask : rd
   // Bounded wait for the line; a timeout ends the run
   task automatic wait_irq(input int lim);
      n = 0;
      while (irq_req !== 1'b1 && n < lim) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= lim) begin
         bad_count++;
         end_sim();
      end
   endtask : wait_irq
   initial begin
      void'($urandom(34));
      clk(16);
      srst <= 1'b0;
      rd(CFG, 32'h0000_0000);
      rd(12'h00d0, 32'h0000_0000);
      n = $urandom_range(7);
      src_enables <= 8'h01 << n;
      src_flags <= ~(8'h01 << n);
      clk(2);
      rd(CFG, 32'h0000_0000);
      src_flags <= 8'hff;
      rd(CFG, 32'h0008_0000);
      see(1'b1, 32'h0000_0000);
      $display("test gating done");
      wr(CFG, 32'h0004_0002);
      clk(1);
      see(1'b1, 32'h0000_0001);
      src_flags <= 8'h00;
      clk(1);
      src_flags <= 8'hff;
      rd(CFG, 32'h000c_0102);
      wait_irq(400);
      see(1'b1, {31'h0, n >= 190 && n <= 305});
      src_flags <= 8'h00;
      clk(150);
      src_flags <= 8'hff;
      wr(CFG, 32'h0004_0202);
      wait_irq(400);
      see(1'b1, {31'h0, n >= 195});
      $display("test holdoff done");
      src_flags <= 8'h00;
      clk(2);
      wake_int_en <= 1'b1;
      wake_event <= 1'b1;
      wakeup_source_bits <= 2'h1;
      clk(1);
      wake_event <= 1'b0;
      wait_irq(4);
      wr(IHC_OFS_IRQ_STATUS, 32'h0000_0000);
      rd(IHC_OFS_IRQ_STATUS, 32'h0000_0002);
      wakeup_source_bits <= 2'h0;
      clk(2);
      rd(IHC_OFS_IRQ_STATUS, 32'h0000_0000);
      dma_interrupt_flag <= 1'b1;
      rd(IHC_OFS_IRQ_STATUS, 32'h0000_0001);
      rd(CFG, 32'h0004_0102);
      src_flags <= 8'hff;
      wr(CFG, 32'h0004_0000);
      wait_irq(3);
      see(1'b1, 32'h0000_0001);
      wr(CFG, 32'h0004_0001);
      src_flags <= 8'h00;
      clk(1);
      src_flags <= 8'hff;
      wait_irq(400);
      see(1'b1, {31'h0, n >= 90 && n <= 110});
      $display("test wake and zero done");
      end_sim();
   end
endmodule : ihc_irq_holdoff_ctrl_tb
`default_nettype wire
